/* bench/dts_speed_select_chk.sv */
// port checker for the terminal speed selection block
// assumes one clock and a synchronous active low reset
`timescale 1ns/100ps
module dts_speed_select_chk (
    input wire logic              clock_in,
    input wire logic              reset_n_in,
    input wire logic              motor_running_in,
    input wire logic              wb_cyc_in,
    input wire logic              wb_stb_in,
    input wire logic              wb_ack_out,
    input wire logic [31:0]       wb_dat_out,
    input wire logic              ref_direct_load_out,
    input wire dts_pkg::dts_src_t active_src_out,
    input wire logic              alt_motor_set_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence s_ans;
        wb_ack_out ##1 !wb_ack_out;
    endsequence
    AST_ACK_REQ: assert property (s_req |=> s_ans)
        else $error("bus answer not one cycle");
    AST_ACK_IDLE: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
        else $error("ack without request");
    AST_DAT_IDLE: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
        else $error("read data outside ack");
    AST_ALT_RUN: assert property ($past(motor_running_in) |->
        $stable(alt_motor_set_out)) else $error("motor set moved running");
    AST_SRC_RUN: assert property ($past(motor_running_in) |->
        $stable(active_src_out)) else $error("source moved running");
    AST_LOAD_STOP: assert property (ref_direct_load_out |->
        !motor_running_in && !$past(motor_running_in))
        else $error("direct load while running");
    AST_LOAD_PULSE: assert property (ref_direct_load_out |=>
        !ref_direct_load_out) else $error("direct load too long");
endmodule
bind dts_speed_select dts_speed_select_chk chk_u (.clock_in, .reset_n_in,
    .motor_running_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out, .wb_dat_out,
    .ref_direct_load_out, .active_src_out, .alt_motor_set_out);

/* bench/dts_term_model.sv */
// terminal pins and keypad side: levels change only after a clock edge
// assumes the bench asks for pin levels on want_in
`timescale 1ns/100ps
module dts_term_model (
    input  wire logic       clock_in,
    input  wire logic [6:0] want_in,
    output logic      [6:0] pin_out
);
    // terminals follow want_in one clock later, set by the bench
    always @(posedge clock_in) begin
        pin_out <= want_in;
    end
endmodule

/* bench/tb_dts_speed_select.sv */
// self-checking bench for the terminal speed selection block
// assumes class 0 defaults and short debounce and pot tick counts
`timescale 1ns/100ps
module tb_dts_speed_select;
    logic clock_in = 1'b0, reset_n_in = 1'b0, motor_running_in = 1'b0;
    logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
    logic [31:0] wb_adr_in = 32'h0, wb_dat_in = 32'h0, wb_dat_out, q;
    logic [6:0] want = 7'h00, terminal_in;
    logic wb_ack_out, ref_direct_load_out, alt_motor_set_out;
    logic [15:0] speed_ref_out, s;
    logic [1:0] ramp_pair_out;
    dts_pkg::dts_src_t active_src_out;
    dts_pkg::dts_ramp_t ramp_time_out;
    int fail_count = 0, checks = 0;
    always #2.5 clock_in = ~clock_in;
    dts_term_model term_u (.clock_in, .want_in(want), .pin_out(terminal_in));
    dts_speed_select #(.DEB_CYCLES(4), .POT_TICK_CYCLES(8)) dut_u (
        .clock_in, .reset_n_in, .terminal_in, .analog_ref_in(16'h0000),
        .option_ref_in(16'h0000), .motor_running_in, .wb_cyc_in, .wb_stb_in,
        .wb_we_in, .wb_adr_in, .wb_sel_in(4'hF), .wb_dat_in, .wb_dat_out,
        .wb_ack_out, .speed_ref_out, .ref_direct_load_out, .active_src_out,
        .alt_motor_set_out, .ramp_pair_out, .ramp_time_out);
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            $display("BAD %0t got %h want %h", $time, g, e);
            fail_count++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        {wb_cyc_in, wb_stb_in, wb_we_in} <= {2'b11, w};
        wb_adr_in <= {24'h0, a};
        wb_dat_in <= d;
        do begin
            @(posedge clock_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 50);
        q = wb_dat_out;
        {wb_cyc_in, wb_stb_in} <= 2'b00;
        if (n >= 50) begin
            fail_count++;
            final_report;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic setp(input logic [6:0] v);
        @(posedge clock_in);
        want <= v;
        repeat (14) @(posedge clock_in);
    endtask
    task automatic run(input logic v);
        @(posedge clock_in);
        motor_running_in <= v;
        repeat (3) @(posedge clock_in);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_map;
        bus(1'b1, 8'h00, 32'h01DC4321);
        rd(8'h00, 32'h00DC4321);
        run(1'b1);
        bus(1'b1, 8'h00, 32'h0BDC4321);
        rd(8'h00, 32'h00DC4321);
        run(1'b0);
        bus(1'b1, 8'h00, 32'h0BDC4321);
        rd(8'h00, 32'h0BDC4321);
        rd(8'h70, 32'h0);
    endtask
    task automatic t_ramp;
        rd(8'h40, 32'h000000C8);
        rd(8'h48, 32'h0000012C);
        for (int p = 0; p < 4; p++) begin
            setp(7'(p << 4));
            chk(ramp_pair_out, p);
            chk(ramp_time_out.accel, 16'h00C8 + 16'h0064 * p);
        end
    endtask
    task automatic t_steps;
        for (int i = 0; i < 8; i++) bus(1'b1, 8'(8'h20 + 4 * i), 32'h100 + i);
        bus(1'b1, 8'h08, 32'h55);
        for (int i = 1; i < 8; i++) begin
            setp(7'(i));
            chk(speed_ref_out, 32'h100 + i);
        end
        setp(7'h0F);
        chk(speed_ref_out, 32'h100);
        setp(7'h00);
        chk(speed_ref_out, 32'h55);
    endtask
    task automatic t_alt;
        bus(1'b1, 8'h10, 32'h0777);
        bus(1'b1, 8'h14, 32'h0888);
        run(1'b1);
        setp(7'h40);
        chk(alt_motor_set_out, 1'b0);
        run(1'b0);
        chk(alt_motor_set_out, 1'b1);
        chk(ramp_time_out, 32'h07770888);
        setp(7'h00);
    endtask
    task automatic t_pot;
        bus(1'b1, 8'h00, 32'h00000875);
        setp(7'h01);
        setp(7'h00);
        s = speed_ref_out;
        repeat (20) @(posedge clock_in);
        chk(speed_ref_out, s);
        setp(7'h04);
        rd(8'h60, s);
        setp(7'h02);
        chk(speed_ref_out, 32'h0);
        rd(8'h60, 32'h0);
    endtask
    task automatic t_ovr;
        bus(1'b1, 8'h04, 32'hC4);
        bus(1'b1, 8'h00, 32'hA00);
        chk(active_src_out, 32'hC4);
        setp(7'h04);
        chk(active_src_out, 32'h0);
        chk(speed_ref_out, 32'h55);
        run(1'b1);
        setp(7'h00);
        chk(speed_ref_out, 32'h55);
        run(1'b0);
        chk(active_src_out, 32'hC4);
    endtask
    initial begin
        repeat (4) @(posedge clock_in);
        reset_n_in <= 1'b1;
        t_map;
        t_ramp;
        t_steps;
        t_alt;
        t_pot;
        t_ovr;
        final_report;
    end
endmodule

/* hw/dts_consts.svh */
// constants for the terminal speed selection block
// assumes a 200 MHz control clock and a 32-bit classic wishbone slave port
//
// Functional notes
// - inch off: step terminals index stored speeds 1..7; zero uses source
// - inch terminal on selects stored inch speed over step and pot terminals; local override wins
// - pot raise/lower ramp reference while on, hold otherwise, source ignored
// - pot with local override: speed from pot, all else from override
// - pot store saves present reference; resumed pot run starts from it
// - pot reset clears retained pot value to zero
// - pot reset ramps to zero while running, loads zero directly when stopped
// - analog source with freeze on holds reference; released applies new one
// - local override takes run, reference, torque from keypad, speed mode
// - override change applies at once when stopped, else after stopping
// - source and mode changes during override wait for override off, stopped
// - alternate motor terminal selects second parameter set
// - alternate motor change while running waits until motor stopped
// - four ramp pairs, defaults by capacity class
// - ramp low weight 1, ramp high weight 2, both off pair 1
// - duplicate terminal function reads unused; no remapping while running
`ifndef DTS_CONSTS_SVH
`define DTS_CONSTS_SVH

`define DTS_CLK_MHZ         200
`define DTS_DEBOUNCE_US     100
`define DTS_POT_TICK_US     1000

`define DTS_OFF_TERM_MAP    8'h00
`define DTS_OFF_SRC_SEL     8'h04
`define DTS_OFF_KEYPAD      8'h08
`define DTS_OFF_POT_CFG     8'h0C
`define DTS_OFF_ALT_ACC     8'h10
`define DTS_OFF_ALT_DEC     8'h14
`define DTS_OFF_STATUS      8'h18
`define DTS_OFF_SPEED_REF   8'h1C
`define DTS_OFF_STEP_BASE   8'h20
`define DTS_OFF_RAMP_BASE   8'h40
`define DTS_OFF_POT_RETAIN  8'h60

`define DTS_ST_STEP_LSB     0
`define DTS_ST_INCH         3
`define DTS_ST_POT          4
`define DTS_ST_OVR          5
`define DTS_ST_ALT          6
`define DTS_ST_PAIR_LSB     7
`define DTS_ST_TERM_LSB     9
`define DTS_ST_SRC_LSB      17
`define DTS_ST_RUN          25

`define DTS_RST_KEYPAD      16'h0000
`define DTS_RST_POT_STEP    16'h0001
`define DTS_RST_POT_MAX     16'hFFFF
`define DTS_RST_SPEED       16'h0000

// ramp time defaults in units of 10 ms, per capacity class and pair
`define DTS_RT_C0_P1        16'd200
`define DTS_RT_C0_P2        16'd300
`define DTS_RT_C0_P3        16'd400
`define DTS_RT_C0_P4        16'd500
`define DTS_RT_C1_P1        16'd1000
`define DTS_RT_C1_P2        16'd1200
`define DTS_RT_C1_P3        16'd1400
`define DTS_RT_C1_P4        16'd1600
`define DTS_RT_C2_P1        16'd2000
`define DTS_RT_C2_P2        16'd2400
`define DTS_RT_C2_P3        16'd2800
`define DTS_RT_C2_P4        16'd3200
`define DTS_RT_C3_P1        16'd3000
`define DTS_RT_C3_P2        16'd3500
`define DTS_RT_C3_P3        16'd4000
`define DTS_RT_C3_P4        16'd4500

`endif

/* hw/dts_debounce.sv */
// one terminal: three-stage synchroniser and stability filter
// assumes an asynchronous raw pin and the control clock
`timescale 1ns/100ps
module dts_debounce #(
    parameter int DEB_CYCLES = 20000,
    parameter int CNT_W      = 15
) (
    input  wire logic clock_in,
    input  wire logic reset_n_in,
    input  wire logic raw_in,
    output logic      state_out
);

    logic             s1_reg;
    logic             s2_reg;
    logic             s3_reg;
    logic [CNT_W-1:0] cnt_reg;

    wire agree   = (s2_reg == s3_reg);
    wire differs = agree & (s3_reg != state_out);
    wire settled = (cnt_reg == CNT_W'(DEB_CYCLES - 1));

    generate
        if (DEB_CYCLES < 1 || (DEB_CYCLES - 1) >= (1 << CNT_W)) begin : g_chk
            $error("debounce count does not fit its counter");
        end
    endgenerate

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            s1_reg    <= 1'b0;
            s2_reg    <= 1'b0;
            s3_reg    <= 1'b0;
            cnt_reg   <= '0;
            state_out <= 1'b0;
        end else begin
            s1_reg <= raw_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (!differs) begin
                cnt_reg <= '0;
            end else if (settled) begin
                cnt_reg   <= '0;
                state_out <= s3_reg;
            end else begin
                cnt_reg <= cnt_reg + CNT_W'(1);
            end
        end
    end

endmodule

/* hw/dts_pkg.sv */
// types shared by the terminal speed selection block
// assumes nothing beyond the constants header
package dts_pkg;

    typedef enum logic [3:0] {
        dts_fn_none,
        dts_fn_step_l,
        dts_fn_step_m,
        dts_fn_step_h,
        dts_fn_inch,
        dts_fn_pot_raise,
        dts_fn_pot_lower,
        dts_fn_pot_reset,
        dts_fn_pot_store,
        dts_fn_ref_freeze,
        dts_fn_local_ovr,
        dts_fn_alt_motor,
        dts_fn_ramp_l,
        dts_fn_ramp_h
    } dts_func_t;

    typedef enum logic [1:0] {
        dts_ref_keypad,
        dts_ref_analog,
        dts_ref_option,
        dts_ref_spare
    } dts_ref_src_t;

    typedef struct packed {
        logic [1:0]   mode;
        logic [1:0]   trq;
        dts_ref_src_t refs;
        logic [1:0]   run;
    } dts_src_t;

    typedef struct packed {
        logic [15:0] accel;
        logic [15:0] decel;
    } dts_ramp_t;

endpackage

/* hw/dts_speed_select.sv */
// terminal speed selection: step speeds, inch, pot, freeze, override,
// alternate motor set and ramp pair selection, with a wishbone slave
// assumes motor_running_in and analog/option references on this clock
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/100ps
`include "dts_consts.svh"
module dts_speed_select #(
    parameter int N_TERM          = 7,
    parameter int CAP_CLASS       = 0,
    parameter int DEB_CYCLES      = `DTS_DEBOUNCE_US * `DTS_CLK_MHZ,
    parameter int POT_TICK_CYCLES = `DTS_POT_TICK_US * `DTS_CLK_MHZ
) (
    input  wire logic          clock_in,
    input  wire logic          reset_n_in,
    input  wire logic [N_TERM-1:0] terminal_in,
    input  wire logic [15:0]   analog_ref_in,
    input  wire logic [15:0]   option_ref_in,
    input  wire logic          motor_running_in,
    input  wire logic          wb_cyc_in,
    input  wire logic          wb_stb_in,
    input  wire logic          wb_we_in,
    input  wire logic [31:0]   wb_adr_in,
    input  wire logic [3:0]    wb_sel_in,
    input  wire logic [31:0]   wb_dat_in,
    output logic [31:0]        wb_dat_out,
    output logic               wb_ack_out,
    output logic [15:0]        speed_ref_out,
    output logic               ref_direct_load_out,
    output dts_pkg::dts_src_t  active_src_out,
    output logic               alt_motor_set_out,
    output logic [1:0]         ramp_pair_out,
    output dts_pkg::dts_ramp_t ramp_time_out
);

    localparam int DEB_W  = $clog2(DEB_CYCLES + 1);
    localparam int TICK_W = $clog2(POT_TICK_CYCLES + 1);
    localparam int MAP_W  = 4 * N_TERM;
    localparam logic [7:0] STEP_BASE = `DTS_OFF_STEP_BASE;
    localparam logic [7:0] RAMP_BASE = `DTS_OFF_RAMP_BASE;

    generate
        if (N_TERM < 1 || N_TERM > 8 || CAP_CLASS < 0 || CAP_CLASS > 3 ||
            POT_TICK_CYCLES < 1) begin : g_chk
            $error("unsupported terminal count, class or tick");
        end
    endgenerate

    function automatic logic [15:0] ramp_default(input int cls,
                                                 input int pair);
        logic [15:0] v;
        v = `DTS_RT_C0_P1;
        case (cls * 4 + pair)
            0:       v = `DTS_RT_C0_P1;
            1:       v = `DTS_RT_C0_P2;
            2:       v = `DTS_RT_C0_P3;
            3:       v = `DTS_RT_C0_P4;
            4:       v = `DTS_RT_C1_P1;
            5:       v = `DTS_RT_C1_P2;
            6:       v = `DTS_RT_C1_P3;
            7:       v = `DTS_RT_C1_P4;
            8:       v = `DTS_RT_C2_P1;
            9:       v = `DTS_RT_C2_P2;
            10:      v = `DTS_RT_C2_P3;
            11:      v = `DTS_RT_C2_P4;
            12:      v = `DTS_RT_C3_P1;
            13:      v = `DTS_RT_C3_P2;
            14:      v = `DTS_RT_C3_P3;
            15:      v = `DTS_RT_C3_P4;
            default: v = `DTS_RT_C0_P1;
        endcase
        return v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // terminal conditioning

    logic [N_TERM-1:0] term_state;

    generate
        for (genvar t = 0; t < N_TERM; t++) begin : g_term
            dts_debounce #(
                .DEB_CYCLES(DEB_CYCLES),
                .CNT_W     (DEB_W)
            ) u_deb (
                .clock_in  (clock_in),
                .reset_n_in(reset_n_in),
                .raw_in    (terminal_in[t]),
                .state_out (term_state[t])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [MAP_W-1:0]   map_reg;
    dts_pkg::dts_src_t  src_sel_reg;
    logic [15:0]        keypad_reg;
    logic [15:0]        pot_step_reg;
    logic [15:0]        pot_max_reg;
    logic [15:0]        alt_acc_reg;
    logic [15:0]        alt_dec_reg;
    logic [15:0]        step_reg [8];
    logic [15:0]        ramp_reg [8];
    logic [15:0]        pot_value_reg;
    logic [15:0]        pot_retain_reg;
    logic [15:0]        analog_held_reg;
    logic               ovr_act_reg;
    logic               run_prev_reg;
    logic               reset_prev_reg;
    logic               store_prev_reg;
    logic [TICK_W-1:0]  tick_cnt_reg;
    logic [31:0]        rd_data;
    logic [MAP_W-1:0]   eff_map;
    logic [15:0]        fn_on;
    logic [15:0]        fn_asg;
    logic [15:0]        ref_next;
    logic [31:0]        status;

    wire bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    wire bus_wr  = bus_req & wb_we_in;
    wire hi_ok   = (wb_adr_in[31:8] == 24'h000000);
    wire [7:0] a = wb_adr_in[7:0];
    wire hit_map  = hi_ok & (a == `DTS_OFF_TERM_MAP);
    wire hit_src  = hi_ok & (a == `DTS_OFF_SRC_SEL);
    wire hit_kpd  = hi_ok & (a == `DTS_OFF_KEYPAD);
    wire hit_pot  = hi_ok & (a == `DTS_OFF_POT_CFG);
    wire hit_aacc = hi_ok & (a == `DTS_OFF_ALT_ACC);
    wire hit_adec = hi_ok & (a == `DTS_OFF_ALT_DEC);
    wire hit_step = hi_ok & (a[7:5] == STEP_BASE[7:5]) & (a[1:0] == 2'b00);
    wire hit_ramp = hi_ok & (a[7:5] == RAMP_BASE[7:5]) & (a[1:0] == 2'b00);
    wire [2:0] bank_idx = a[4:2];
    wire [MAP_W-1:0] map_wr = MAP_W'(merge(32'(map_reg), wb_dat_in,
                                           wb_sel_in));
    wire [31:0] src_wr  = merge({24'h000000, src_sel_reg}, wb_dat_in,
                                wb_sel_in);
    wire [31:0] kpd_wr  = merge({16'h0000, keypad_reg}, wb_dat_in, wb_sel_in);
    wire [31:0] pot_wr  = merge({pot_max_reg, pot_step_reg}, wb_dat_in,
                                wb_sel_in);
    wire [31:0] aacc_wr = merge({16'h0000, alt_acc_reg}, wb_dat_in,
                                wb_sel_in);
    wire [31:0] adec_wr = merge({16'h0000, alt_dec_reg}, wb_dat_in,
                                wb_sel_in);

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            map_reg      <= '0;
            src_sel_reg  <= '0;
            keypad_reg   <= `DTS_RST_KEYPAD;
            pot_step_reg <= `DTS_RST_POT_STEP;
            pot_max_reg  <= `DTS_RST_POT_MAX;
            alt_acc_reg  <= ramp_default(CAP_CLASS, 0);
            alt_dec_reg  <= ramp_default(CAP_CLASS, 0);
        end else if (bus_wr) begin
            if (hit_map && !motor_running_in) begin
                map_reg <= map_wr;
            end
            if (hit_src) begin
                src_sel_reg <= src_wr[7:0];
            end
            if (hit_kpd) begin
                keypad_reg <= kpd_wr[15:0];
            end
            if (hit_pot) begin
                pot_step_reg <= pot_wr[15:0];
                pot_max_reg  <= pot_wr[31:16];
            end
            if (hit_aacc) begin
                alt_acc_reg <= aacc_wr[15:0];
            end
            if (hit_adec) begin
                alt_dec_reg <= adec_wr[15:0];
            end
        end
    end

    generate
        for (genvar i = 0; i < 8; i++) begin : g_bank
            wire [31:0] st_wr = merge({16'h0000, step_reg[i]}, wb_dat_in,
                                      wb_sel_in);
            wire [31:0] rt_wr = merge({16'h0000, ramp_reg[i]}, wb_dat_in,
                                      wb_sel_in);
            always_ff @(posedge clock_in) begin
                if (!reset_n_in) begin
                    step_reg[i] <= `DTS_RST_SPEED;
                    ramp_reg[i] <= ramp_default(CAP_CLASS, i / 2);
                end else if (bus_wr && bank_idx == 3'(i)) begin
                    if (hit_step) begin
                        step_reg[i] <= st_wr[15:0];
                    end
                    if (hit_ramp) begin
                        ramp_reg[i] <= rt_wr[15:0];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // function decode: lowest terminal keeps a shared function

    always_comb begin
        logic       dup;
        logic [3:0] code;
        dup    = 1'b0;
        code   = 4'h0;
        fn_on  = 16'h0000;
        fn_asg = 16'h0000;
        eff_map = '0;
        for (int t = 0; t < N_TERM; t++) begin
            dup = 1'b0;
            for (int u = 0; u < t; u++) begin
                if (map_reg[4*u +: 4] == map_reg[4*t +: 4]) begin
                    dup = 1'b1;
                end
            end
            code = dup ? 4'h0 : map_reg[4*t +: 4];
            if (code > 4'(dts_pkg::dts_fn_ramp_h)) begin
                code = 4'h0;
            end
            eff_map[4*t +: 4] = code;
            if (code != 4'h0) begin
                fn_asg[code] = 1'b1;
                fn_on[code]  = term_state[t];
            end
        end
    end

    wire inch_on  = fn_on[dts_pkg::dts_fn_inch];
    wire [2:0] step_idx = {fn_on[dts_pkg::dts_fn_step_h],
                           fn_on[dts_pkg::dts_fn_step_m],
                           fn_on[dts_pkg::dts_fn_step_l]};
    wire pot_mode = fn_asg[dts_pkg::dts_fn_pot_raise] |
                    fn_asg[dts_pkg::dts_fn_pot_lower];
    wire raise_on = fn_on[dts_pkg::dts_fn_pot_raise];
    wire lower_on = fn_on[dts_pkg::dts_fn_pot_lower];
    wire reset_on = fn_on[dts_pkg::dts_fn_pot_reset];
    wire store_on = fn_on[dts_pkg::dts_fn_pot_store];
    wire reset_edge = reset_on & ~reset_prev_reg;
    wire store_edge = store_on & ~store_prev_reg;
    wire resume = pot_mode & motor_running_in & ~run_prev_reg;
    wire tick = (tick_cnt_reg == TICK_W'(POT_TICK_CYCLES - 1));
    wire [16:0] pot_sum = {1'b0, pot_value_reg} + {1'b0, pot_step_reg};
    wire [15:0] pot_up = (pot_sum > {1'b0, pot_max_reg}) ? pot_max_reg
                                                          : pot_sum[15:0];
    wire [15:0] pot_dn = (pot_value_reg > pot_step_reg)
                         ? pot_value_reg - pot_step_reg : 16'h0000;
    wire freeze = fn_on[dts_pkg::dts_fn_ref_freeze] &
                  (active_src_out.refs == dts_pkg::dts_ref_analog);
    wire [1:0] pair = {fn_on[dts_pkg::dts_fn_ramp_h],
                       fn_on[dts_pkg::dts_fn_ramp_l]};

    ////////////////////////////////////////////////////////////////////////
    // pot state, analog hold, deferred selections

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            tick_cnt_reg    <= '0;
            pot_value_reg   <= '0;
            pot_retain_reg  <= '0;
            analog_held_reg <= '0;
            run_prev_reg    <= 1'b0;
            reset_prev_reg  <= 1'b0;
            store_prev_reg  <= 1'b0;
            ovr_act_reg     <= 1'b0;
            alt_motor_set_out <= 1'b0;
            active_src_out  <= '0;
        end else begin
            tick_cnt_reg   <= tick ? '0 : tick_cnt_reg + TICK_W'(1);
            run_prev_reg   <= motor_running_in;
            reset_prev_reg <= reset_on;
            store_prev_reg <= store_on;
            if (reset_edge) begin
                pot_value_reg <= 16'h0000;
            end else if (resume) begin
                pot_value_reg <= pot_retain_reg;
            end else if (tick && raise_on && !lower_on) begin
                pot_value_reg <= pot_up;
            end else if (tick && lower_on && !raise_on) begin
                pot_value_reg <= pot_dn;
            end
            if (reset_edge) begin
                pot_retain_reg <= 16'h0000;
            end else if (store_edge) begin
                pot_retain_reg <= speed_ref_out;
            end
            if (!freeze) begin
                analog_held_reg <= analog_ref_in;
            end
            if (!motor_running_in) begin
                ovr_act_reg       <= fn_on[dts_pkg::dts_fn_local_ovr];
                alt_motor_set_out <= fn_on[dts_pkg::dts_fn_alt_motor];
                active_src_out    <= fn_on[dts_pkg::dts_fn_local_ovr]
                                     ? '0 : src_sel_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reference and ramp selection

    wire [15:0] src_ref = (active_src_out.refs == dts_pkg::dts_ref_analog)
                          ? analog_held_reg
                          : (active_src_out.refs == dts_pkg::dts_ref_option)
                          ? option_ref_in : keypad_reg;

    always_comb begin
        ref_next = src_ref;
        if (ovr_act_reg) begin
            ref_next = pot_mode ? pot_value_reg : keypad_reg;
        end else if (inch_on) begin
            ref_next = step_reg[0];
        end else if (pot_mode) begin
            ref_next = pot_value_reg;
        end else if (step_idx != 3'b000) begin
            ref_next = step_reg[step_idx];
        end
    end

    wire use_alt = alt_motor_set_out & (pair == 2'b00);
    wire [15:0] acc_sel = use_alt ? alt_acc_reg : ramp_reg[{pair, 1'b0}];
    wire [15:0] dec_sel = use_alt ? alt_dec_reg : ramp_reg[{pair, 1'b1}];

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            speed_ref_out       <= '0;
            ref_direct_load_out <= 1'b0;
            ramp_pair_out       <= 2'b00;
            ramp_time_out       <= '0;
        end else begin
            speed_ref_out       <= ref_next;
            ref_direct_load_out <= reset_edge & ~motor_running_in;
            ramp_pair_out       <= pair;
            ramp_time_out       <= {acc_sel, dec_sel};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wishbone read and acknowledge

    always_comb begin
        status = 32'h00000000;
        status[`DTS_ST_STEP_LSB +: 3] = step_idx;
        status[`DTS_ST_INCH]          = inch_on;
        status[`DTS_ST_POT]           = pot_mode;
        status[`DTS_ST_OVR]           = ovr_act_reg;
        status[`DTS_ST_ALT]           = alt_motor_set_out;
        status[`DTS_ST_PAIR_LSB +: 2] = pair;
        status[`DTS_ST_TERM_LSB +: N_TERM] = term_state;
        status[`DTS_ST_SRC_LSB +: 8]  = active_src_out;
        status[`DTS_ST_RUN]           = motor_running_in;
    end

    always_comb begin
        rd_data = 32'h00000000;
        if (hit_map) begin
            rd_data = 32'(eff_map);
        end else if (hit_src) begin
            rd_data = {24'h000000, src_sel_reg};
        end else if (hit_kpd) begin
            rd_data = {16'h0000, keypad_reg};
        end else if (hit_pot) begin
            rd_data = {pot_max_reg, pot_step_reg};
        end else if (hit_aacc) begin
            rd_data = {16'h0000, alt_acc_reg};
        end else if (hit_adec) begin
            rd_data = {16'h0000, alt_dec_reg};
        end else if (hi_ok && a == `DTS_OFF_STATUS) begin
            rd_data = status;
        end else if (hi_ok && a == `DTS_OFF_SPEED_REF) begin
            rd_data = {16'h0000, speed_ref_out};
        end else if (hi_ok && a == `DTS_OFF_POT_RETAIN) begin
            rd_data = {16'h0000, pot_retain_reg};
        end else if (hit_step) begin
            rd_data = {16'h0000, step_reg[bank_idx]};
        end else if (hit_ramp) begin
            rd_data = {16'h0000, ramp_reg[bank_idx]};
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h00000000;
        end else begin
            wb_ack_out <= bus_req;
            wb_dat_out <= bus_req ? rd_data : 32'h00000000;
        end
    end

endmodule
